//--- verilog/sdpc_top.sv
// AHB-Lite register bank for the second loop's divider and power configuration
//
// Overview of operation
// - Bits 31:10 fraction 27:6; fractional uses 28
// - Integer mode: top three bits interp or modulation
// - Fractional full interpolation: 28-bit fraction
// - Bits 9:4 fraction low or modulus low
// - Bit 3 powers charge pump and detector
// - Bit 2 powers oscillator, default one
// - Bit 1 powers feedback divider, default one
// - Power-down pin disables all three subsystems
// - Bit 0 selects readback or lock pin
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "sdpc_regs.svh"
module sdpc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic loop_powerdown_pin,
    input wire logic loss_of_lock,
    input wire logic serial_read_data,
    input wire logic [1:0] interp_sel,
    output logic shared_readback_lock_pin,
    output logic charge_pump_detector_power_en,
    output logic oscillator_power_up,
    output logic fb_divider_power_up,
    output logic [7:0] int_div,
    output logic [27:0] frac_div,
    output logic [5:0] modulus_low,
    output logic [2:0] interp_bits,
    output logic [2:0] mash_bits,
    output logic irq
);
    import sdpc_pkg::*;

    logic [39:0] second_loop_divider_power_config;
    sdpc_mode_t mode;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] irq_event;
    logic lol_q;
    logic pd_q;
    logic int_low_q;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] next_rdata;
    logic [7:0] dec_int;
    logic [27:0] dec_frac;
    logic [5:0] dec_mod;
    logic [2:0] dec_interp;
    logic [2:0] dec_mash;
    logic pw_pfd;
    logic pw_vco;
    logic pw_fbd;
    logic addr_ok;
    logic wr_stat;
    logic [1:0] mode_code;

    assign addr_ok = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_stat = wr_pend & (wr_addr == `SDPC_OFF_IRQ_STAT);

    // Write data phase follows the captured address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else if (clk_en) begin
            wr_pend <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr <= haddr;
            end
        end
    end

    // Defaults power oscillator and feedback divider, leave charge pump and detector off, pin on readback
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_loop_divider_power_config <= `SDPC_CFG_RESET;
        end else if (clk_en && wr_pend) begin
            if (wr_addr == `SDPC_OFF_CFG_LO) begin
                second_loop_divider_power_config[31:0] <= hwdata;
            end else if (wr_addr == `SDPC_OFF_CFG_HI) begin
                second_loop_divider_power_config[39:32] <= hwdata[7:0];
            end
        end
    end

    // Mode comes from configuration outside the 40-bit word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= SDPC_MODE_FRACTIONAL;
        end else if (clk_en && wr_pend && wr_addr == `SDPC_OFF_MODE) begin
            unique case (hwdata[1:0])
                2'h0: mode <= SDPC_MODE_INTEGER;
                2'h2: mode <= SDPC_MODE_RATIONAL;
                default: mode <= SDPC_MODE_FRACTIONAL;
            endcase
        end
    end

    always_comb begin
        unique case (mode)
            SDPC_MODE_INTEGER: mode_code = 2'h0;
            SDPC_MODE_RATIONAL: mode_code = 2'h2;
            default: mode_code = 2'h1;
        endcase
    end

    sdpc_divider_decode u_decode (
        .cfg(second_loop_divider_power_config),
        .mode(mode),
        .interp_sel(interp_sel),
        .int_div(dec_int),
        .frac_div(dec_frac),
        .modulus_low(dec_mod),
        .interp_bits(dec_interp),
        .mash_bits(dec_mash)
    );

    sdpc_power_gate u_power (
        .power_bits(second_loop_divider_power_config[`SDPC_BIT_PFD:`SDPC_BIT_FBD]),
        .loop_powerdown_pin(loop_powerdown_pin),
        .charge_pump_detector_on(pw_pfd),
        .oscillator_on(pw_vco),
        .fb_divider_on(pw_fbd)
    );

    // Registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            charge_pump_detector_power_en <= 1'b0;
            oscillator_power_up <= 1'b0;
            fb_divider_power_up <= 1'b0;
            int_div <= 8'h00;
            frac_div <= 28'h000_0000;
            modulus_low <= 6'h00;
            interp_bits <= 3'h0;
            mash_bits <= 3'h0;
            shared_readback_lock_pin <= 1'b0;
        end else if (clk_en) begin
            charge_pump_detector_power_en <= pw_pfd;
            oscillator_power_up <= pw_vco;
            fb_divider_power_up <= pw_fbd;
            int_div <= dec_int;
            frac_div <= dec_frac;
            modulus_low <= dec_mod;
            interp_bits <= dec_interp;
            mash_bits <= dec_mash;
            // Pin carries lock loss as an interrupt level when selected
            shared_readback_lock_pin <= second_loop_divider_power_config[`SDPC_BIT_LOCKSEL]
                ? loss_of_lock : serial_read_data;
        end
    end

    // Events: lock loss rising, integer value below minimum, power-down entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lol_q <= 1'b0;
            pd_q <= 1'b0;
            int_low_q <= 1'b0;
        end else if (clk_en) begin
            lol_q <= loss_of_lock;
            pd_q <= loop_powerdown_pin;
            int_low_q <= second_loop_divider_power_config[`SDPC_INT_HI:`SDPC_INT_LO]
                < `SDPC_INT_MIN;
        end
    end

    always_comb begin
        irq_event = 3'h0;
        irq_event[`SDPC_IRQ_LOL] = loss_of_lock & ~lol_q;
        irq_event[`SDPC_IRQ_INTLOW] = (second_loop_divider_power_config[39:32]
            < `SDPC_INT_MIN) & ~int_low_q;
        irq_event[`SDPC_IRQ_PD] = loop_powerdown_pin & ~pd_q;
    end

    // A new event in the clearing cycle survives the write-one-to-clear
    genvar gi;
    generate
        for (gi = 0; gi < `SDPC_IRQ_BITS; gi++) begin : g_irq
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    irq_stat[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (irq_event[gi]) begin
                        irq_stat[gi] <= 1'b1;
                    end else if (wr_stat && hwdata[gi]) begin
                        irq_stat[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= 3'h0;
        end else if (clk_en && wr_pend && wr_addr == `SDPC_OFF_IRQ_MASK) begin
            irq_mask <= hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read data registered at the address phase, valid in the data phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr)
            `SDPC_OFF_CFG_LO: next_rdata = second_loop_divider_power_config[31:0];
            `SDPC_OFF_CFG_HI: next_rdata = {24'h00_0000, second_loop_divider_power_config[39:32]};
            `SDPC_OFF_MODE: next_rdata = {30'h0000_0000, mode_code};
            `SDPC_OFF_STATUS: next_rdata = {28'h000_0000, charge_pump_detector_power_en,
                oscillator_power_up, fb_divider_power_up, loss_of_lock};
            `SDPC_OFF_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
            `SDPC_OFF_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end
endmodule // sdpc_top

//--- verilog/sdpc_regs.svh
// Register map, field positions, reset values and constants of the divider/power block
`ifndef SDPC_REGS_SVH
`define SDPC_REGS_SVH
`define SDPC_OFF_CFG_LO 12'h000
`define SDPC_OFF_CFG_HI 12'h004
`define SDPC_OFF_MODE 12'h008
`define SDPC_OFF_STATUS 12'h00C
`define SDPC_OFF_IRQ_STAT 12'h010
`define SDPC_OFF_IRQ_MASK 12'h014
`define SDPC_INT_HI 39
`define SDPC_INT_LO 32
`define SDPC_FRAC_HI_HI 31
`define SDPC_FRAC_HI_LO 10
`define SDPC_SHARED_HI 9
`define SDPC_SHARED_LO 4
`define SDPC_BIT_PFD 3
`define SDPC_BIT_VCO 2
`define SDPC_BIT_FBD 1
`define SDPC_BIT_LOCKSEL 0
`define SDPC_CFG_RESET 40'h17_0000_03F6
`define SDPC_INT_MIN 8'h17
`define SDPC_IRQ_BITS 3
`define SDPC_IRQ_LOL 0
`define SDPC_IRQ_INTLOW 1
`define SDPC_IRQ_PD 2
`endif

//--- verilog/sdpc_pkg.sv
// Types shared by the divider/power block
package sdpc_pkg;
    typedef enum logic [1:0] {
        SDPC_MODE_INTEGER,
        SDPC_MODE_FRACTIONAL,
        SDPC_MODE_RATIONAL
    } sdpc_mode_t;
    typedef enum logic [1:0] {
        SDPC_ST_IDLE,
        SDPC_ST_DATA
    } sdpc_bus_st_t;
endpackage

//--- verilog/sdpc_divider_decode.sv
// Mode dependent decode of the divider fields
`timescale 1ns/10ps
`include "sdpc_regs.svh"
module sdpc_divider_decode (
    input wire logic [39:0] cfg,
    input wire sdpc_pkg::sdpc_mode_t mode,
    input wire logic [1:0] interp_sel,
    output logic [7:0] int_div,
    output logic [27:0] frac_div,
    output logic [5:0] modulus_low,
    output logic [2:0] interp_bits,
    output logic [2:0] mash_bits
);
    import sdpc_pkg::*;
    logic [2:0] top3;
    assign top3 = cfg[`SDPC_FRAC_HI_HI -: 3];
    assign int_div = cfg[`SDPC_INT_HI:`SDPC_INT_LO];
    always_comb begin
        frac_div = 28'h000_0000;
        modulus_low = 6'h00;
        interp_bits = 3'h0;
        mash_bits = 3'h0;
        unique case (mode)
            SDPC_MODE_FRACTIONAL: begin
                frac_div = cfg[`SDPC_FRAC_HI_HI:`SDPC_SHARED_LO];
            end
            SDPC_MODE_RATIONAL: begin
                frac_div = {cfg[`SDPC_FRAC_HI_HI:`SDPC_FRAC_HI_LO], 6'h00};
                modulus_low = cfg[`SDPC_SHARED_HI:`SDPC_SHARED_LO];
            end
            SDPC_MODE_INTEGER: begin
                // Low six bits take no part here
                if (interp_sel == 2'h3) begin
                    mash_bits = top3;
                end else begin
                    interp_bits = top3;
                end
            end
            default: begin
                frac_div = 28'h000_0000;
            end
        endcase
    end
endmodule // sdpc_divider_decode

//--- verilog/sdpc_power_gate.sv
// Power enables forced off by the loop power-down pin
`timescale 1ns/10ps
`include "sdpc_regs.svh"
module sdpc_power_gate (
    input wire logic [2:0] power_bits,
    input wire logic loop_powerdown_pin,
    output logic charge_pump_detector_on,
    output logic oscillator_on,
    output logic fb_divider_on
);
    // Pin overrides the enable bits
    assign charge_pump_detector_on = power_bits[2] & ~loop_powerdown_pin;
    assign oscillator_on = power_bits[1] & ~loop_powerdown_pin;
    assign fb_divider_on = power_bits[0] & ~loop_powerdown_pin;
endmodule // sdpc_power_gate

//--- bench/sdpc_asserts.sv
// Port-level checker for the divider/power register bank
`timescale 1ns/10ps
`include "sdpc_regs.svh"
module sdpc_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic loop_powerdown_pin,
    input wire logic loss_of_lock,
    input wire logic serial_read_data,
    input wire logic [1:0] interp_sel,
    input wire logic shared_readback_lock_pin,
    input wire logic charge_pump_detector_power_en,
    input wire logic oscillator_power_up,
    input wire logic fb_divider_power_up,
    input wire logic [7:0] int_div,
    input wire logic [27:0] frac_div,
    input wire logic [5:0] modulus_low,
    input wire logic [2:0] interp_bits,
    input wire logic [2:0] mash_bits
);
    logic [39:0] sh;
    logic [1:0] md, wa, aidx;
    logic live, lsrc;
    logic [27:0] efrac;
    logic [2:0] epw, etop;
    logic [5:0] emod;
    logic [7:0] eint;
    assign aidx = (haddr == `SDPC_OFF_CFG_LO) ? 2'h1 : (haddr == `SDPC_OFF_CFG_HI) ? 2'h2 :
        (haddr == `SDPC_OFF_MODE) ? 2'h3 : 2'h0;
    assign lsrc = sh[0] ? loss_of_lock : serial_read_data;
    assign efrac = (md == 2'h1) ? sh[31:4] : (md == 2'h2) ? {sh[31:10], 6'h00} : 28'h000_0000;
    assign epw = sh[3:1];
    assign etop = sh[31:29];
    assign emod = sh[9:4];
    assign eint = sh[39:32];
    // Shadow of the configuration, so decode can be judged without seeing the body
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh <= `SDPC_CFG_RESET;
            md <= 2'h1;
            wa <= 2'h0;
            live <= 1'h0;
        end else begin
            live <= clk_en;
            if (clk_en) begin
                if (wa == 2'h1) sh[31:0] <= hwdata;
                if (wa == 2'h2) sh[39:32] <= hwdata[7:0];
                if (wa == 2'h3) md <= (hwdata[1:0] == 2'h3) ? 2'h1 : hwdata[1:0];
                wa <= (hsel && hready && htrans[1] && hwrite) ? aidx : 2'h0;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_pin_forces_off: assert property (clk_en && loop_powerdown_pin |=>
        !charge_pump_detector_power_en && !oscillator_power_up && !fb_divider_power_up)
        else $error("power enable on while loop held down");
    chk_power_follow: assert property (live && !$past(loop_powerdown_pin) |->
        {charge_pump_detector_power_en, oscillator_power_up, fb_divider_power_up} == $past(epw))
        else $error("power enables differ from config bits");
    chk_lock_route: assert property (live |-> shared_readback_lock_pin == $past(lsrc))
        else $error("shared pin source wrong");
    chk_frac_decode: assert property (live |-> frac_div == $past(efrac))
        else $error("fraction decode wrong");
    chk_modulus_rational: assert property (live && $past(md) == 2'h2 |->
        modulus_low == $past(emod)) else $error("modulus low wrong");
    chk_interp_route: assert property (live && $past(md) == 2'h0 && $past(interp_sel) != 2'h3 |->
        interp_bits == $past(etop)) else $error("interpolation bits wrong");
    chk_mash_route: assert property (live && $past(md) == 2'h0 && $past(interp_sel) == 2'h3 |->
        mash_bits == $past(etop)) else $error("modulation bits wrong");
    chk_int_follow: assert property (live |-> int_div == $past(eint))
        else $error("integer divider wrong");
endmodule // sdpc_asserts
bind sdpc_top sdpc_asserts u_chk (.*);

//--- bench/sdpc_top_test.sv
// Self-checking bench for the divider/power register bank
`timescale 1ns/10ps
`include "sdpc_regs.svh"
module sdpc_top_test;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic clk_en = 1'h1;
    logic hsel = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic loop_powerdown_pin = 1'h0;
    logic loss_of_lock = 1'h0;
    logic serial_read_data = 1'h0;
    logic [1:0] interp_sel = 2'h0;
    logic hready, hreadyout, hresp, shared_readback_lock_pin, irq;
    logic charge_pump_detector_power_en, oscillator_power_up, fb_divider_power_up;
    logic [31:0] hrdata, rd, seed;
    logic [7:0] int_div;
    logic [27:0] frac_div;
    logic [5:0] modulus_low;
    logic [2:0] interp_bits, mash_bits;
    logic [39:0] m_cfg;
    int m_mode, m_stat, m_mask, err_total, num_checks;
    assign hready = hreadyout;
    sdpc_top dut (.*);
    always #12.5 hclk = ~hclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Holds each phase until hready is seen high, as a real master must
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        chk(40'(rd), 40'(e));
        chk(40'(hresp), 40'h00_0000_0000);
    endtask
    // Waits out write, decode and interrupt latency before comparing
    task automatic outs;
        logic [27:0] f;
        logic [2:0] p;
        repeat (3) @(posedge hclk);
        #1;
        f = (m_mode == 1) ? m_cfg[31:4] : (m_mode == 2) ? {m_cfg[31:10], 6'h00} : 28'h000_0000;
        p = loop_powerdown_pin ? 3'h0 : m_cfg[3:1];
        chk(40'(frac_div), 40'(f));
        chk(40'(int_div), 40'(m_cfg[39:32]));
        if (m_mode == 2) chk(40'(modulus_low), 40'(m_cfg[9:4]));
        if (m_mode == 0) chk(40'(interp_sel == 2'h3 ? mash_bits : interp_bits), 40'(m_cfg[31:29]));
        chk(40'({charge_pump_detector_power_en, oscillator_power_up, fb_divider_power_up}), 40'(p));
        chk(40'(shared_readback_lock_pin), 40'(m_cfg[0] ? loss_of_lock : serial_read_data));
        chk(40'(irq), 40'((m_stat & m_mask) != 0));
        rdchk(`SDPC_OFF_IRQ_STAT, 32'(m_stat));
        rdchk(`SDPC_OFF_STATUS, {28'h000_0000, p, loss_of_lock});
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        seed = 32'h0001_4CC1;
        m_cfg = `SDPC_CFG_RESET;
        m_mode = 1;
        m_stat = 0;
        m_mask = 7;
        err_total = 0;
        num_checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        rdchk(`SDPC_OFF_CFG_LO, 32'h0000_03F6);
        rdchk(`SDPC_OFF_CFG_HI, 32'h0000_0017);
        rdchk(`SDPC_OFF_IRQ_MASK, 32'h0000_0000);
        bus(1'h1, `SDPC_OFF_IRQ_MASK, 32'h0000_0007);
        outs;
        for (int md = 0; md < 4; md++) begin
            bus(1'h1, `SDPC_OFF_MODE, 32'(md));
            m_mode = (md == 3) ? 1 : md;
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                interp_sel <= 2'(k);
                serial_read_data <= seed[7];
                // Bits 9:4 never all zero and the integer field never below its floor
                m_cfg = {8'h17 + 8'(seed[31:25]), seed | 32'h0000_0010};
                bus(1'h1, `SDPC_OFF_CFG_LO, m_cfg[31:0]);
                bus(1'h1, `SDPC_OFF_CFG_HI, 32'(m_cfg[39:32]));
                outs;
                rdchk(`SDPC_OFF_CFG_LO, m_cfg[31:0]);
                rdchk(`SDPC_OFF_CFG_HI, 32'(m_cfg[39:32]));
            end
        end
        loop_powerdown_pin <= 1'h1;
        m_stat = 4;
        outs;
        bus(1'h1, `SDPC_OFF_IRQ_STAT, 32'h0000_0004);
        m_stat = 0;
        outs;
        loop_powerdown_pin <= 1'h0;
        bus(1'h1, `SDPC_OFF_IRQ_MASK, 32'h0000_0006);
        m_mask = 6;
        m_cfg[31:0] = 32'h0000_03F7;
        bus(1'h1, `SDPC_OFF_CFG_LO, m_cfg[31:0]);
        loss_of_lock <= 1'h1;
        m_stat = 1;
        outs;
        m_cfg[39:32] = 8'h16;
        bus(1'h1, `SDPC_OFF_CFG_HI, 32'h0000_0016);
        m_stat = 3;
        outs;
        bus(1'h1, `SDPC_OFF_IRQ_STAT, 32'h0000_0003);
        m_stat = 0;
        bus(1'h1, 12'h020, seed);
        rdchk(12'h020, 32'h0000_0000);
        // A write offered while the enable is low must leave no trace
        clk_en <= 1'h0;
        bus(1'h1, `SDPC_OFF_CFG_HI, 32'h0000_0030);
        clk_en <= 1'h1;
        rdchk(`SDPC_OFF_CFG_HI, 32'(m_cfg[39:32]));
        outs;
        tally_and_finish;
    end
endmodule // sdpc_top_test
